// ---- dv/asp_host_test.sv ----
// Self-checking bench for the static RAM host port.
// Assumes the RAM model file; drives the user side at falling edges.
`timescale 1ns/100ps
`default_nettype none

module asp_host_test;
    import asp_pkg::*;

    localparam int PU = 4;
    localparam int SYNC = 2;

    logic                 clock_i = 1'b0;
    logic                 reset_i = 1'b1;
    logic                 req_valid_i = 1'b0;
    asp_req_t             req_i = '0;
    logic                 req_ready_o;
    asp_rsp_t             rsp_o;
    logic                 rsp_valid_o;
    asp_pins_t            pins_o;
    logic [DATA_W-1:0]    dq_o;
    logic                 dq_oe_o;
    logic [DATA_W-1:0]    ram_dq;
    logic [NUM_LANES-1:0] lane_oe;
    logic                 clash;
    logic [DATA_W-1:0]    dq_bus;
    logic [DATA_W-1:0]    float_r = 16'h5a5a;
    int                   mismatches = 0;
    int                   checks_done = 0;
    int                   we_len = 0;

    always #20 clock_i = ~clock_i;
    // Undriven lines wander instead of holding the last value
    always @(posedge clock_i) float_r <= ~float_r;

    assign dq_bus[7:0] = dq_oe_o ? dq_o[7:0] :
                         lane_oe[0] ? ram_dq[7:0] : float_r[7:0];
    assign dq_bus[15:8] = dq_oe_o ? dq_o[15:8] :
                          lane_oe[1] ? ram_dq[15:8] : float_r[15:8];

    asp_host #(.POWERUP_CYCLES(PU), .SYNC_STAGES(SYNC)) u_asp_host (
        .clock_i(clock_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .rsp_o(rsp_o),
        .rsp_valid_o(rsp_valid_o), .pins_o(pins_o), .dq_i(dq_bus),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o));

    asp_sram_model #(.ACC_NS(10)) u_asp_sram_model (
        .pins_i(pins_o), .dq_i(dq_bus), .host_oe_i(dq_oe_o),
        .dq_o(ram_dq), .lane_oe_o(lane_oe), .clash_o(clash));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Strobes low during a write need host data on the bus
    always @(negedge clock_i)
    begin
        if (!reset_i && pins_o.write_strobe_n === 1'b0)
        begin
            check({31'h0, dq_oe_o}, 32'h1);
            check({31'h0, pins_o.chip_select_n}, 32'h0);
            we_len <= we_len + 1;
        end
        else if (we_len != 0)
        begin
            check(we_len, WRITE_PULSE_CYC);
            we_len <= 0;
        end
        if (!reset_i && pins_o.output_drive_n === 1'b0)
            check({31'h0, dq_oe_o}, 32'h0);
    end

    task automatic do_reset();
        int n;
        @(negedge clock_i);
        reset_i = 1'b1;
        req_valid_i = 1'b0;
        repeat (4) @(negedge clock_i);
        check(pins_o, PINS_IDLE);
        check({dq_oe_o, rsp_valid_o, req_ready_o}, 32'h0);
        reset_i = 1'b0;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 20)
        begin
            check(pins_o.chip_select_n, 1'b1);
            @(negedge clock_i);
            n++;
        end
        check(n, PU);
    endtask

    task automatic send(input logic w, input logic [17:0] a,
                        input logic [15:0] d, input logic [1:0] ln);
        int n;
        @(negedge clock_i);
        req_valid_i = 1'b1;
        req_i = '{write: w, addr: a, wdata: d, lanes: ln};
        n = 0;
        while (req_ready_o !== 1'b1 && n < 20)
        begin
            @(negedge clock_i);
            n++;
        end
        check({31'h0, req_ready_o}, 32'h1);
        @(negedge clock_i);
        req_valid_i = 1'b0;
    endtask

    task automatic rd(input logic [17:0] a, input logic [1:0] ln,
                      input logic [15:0] exp);
        int n;
        send(1'b0, a, 16'h0, ln);
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 10)
        begin
            @(negedge clock_i);
            n++;
        end
        check(n, READ_ACCESS_CYC + SYNC);
        check(rsp_o.data, exp);
    endtask

    task automatic t_full();
        send(1'b1, 18'h3ffff, 16'hc3a5, 2'h3);
        send(1'b1, 18'h00000, 16'h1e0f, 2'h3);
        rd(18'h3ffff, 2'h3, 16'hc3a5);
        rd(18'h00000, 2'h3, 16'h1e0f);
        $display("test full_word done");
    endtask

    task automatic t_lanes();
        send(1'b1, 18'h12345, 16'haaaa, 2'h3);
        send(1'b1, 18'h12345, 16'hff34, 2'h1);
        rd(18'h12345, 2'h3, 16'haa34);
        send(1'b1, 18'h12345, 16'h56ff, 2'h2);
        rd(18'h12345, 2'h1, 16'h0034);
        rd(18'h12345, 2'h2, 16'h5600);
        send(1'b1, 18'h20000, 16'hbeef, 2'h0);
        rd(18'h20000, 2'h3, 16'hbeef);
        $display("test byte_lanes done");
    endtask

    task automatic t_reset_mid();
        send(1'b0, 18'h3ffff, 16'h0, 2'h3);
        do_reset();
        rd(18'h3ffff, 2'h3, 16'hc3a5);
        check({31'h0, clash}, 32'h0);
        $display("test mid_reset done");
    endtask

    initial
    begin
        do_reset();
        $display("test powerup done");
        t_full();
        t_lanes();
        t_reset_mid();
        stop_test();
    end

    initial
    begin
        #(200_000);
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire

// ---- dv/asp_sram_model.sv ----
// Behavioural model of the 256K x 16 asynchronous static RAM.
// Assumes the bench resolves the shared data bus and feeds it back on dq_i.
`timescale 1ns/100ps
`default_nettype none

module asp_sram_model
    import asp_pkg::*;
#(
    parameter int ACC_NS = 10
)(
    input  wire asp_pins_t            pins_i,
    input  wire logic [DATA_W-1:0]    dq_i,
    input  wire logic                 host_oe_i,
    output logic      [DATA_W-1:0]    dq_o,
    output logic      [NUM_LANES-1:0] lane_oe_o,
    output var logic                  clash_o
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic              sel;
    logic              standby;
    logic              wr;
    logic              rd;

    assign sel = pins_i.chip_select_n === 1'b0;
    assign standby = !sel;
    assign wr = !standby && pins_i.write_strobe_n === 1'b0;
    assign rd = !standby && pins_i.output_drive_n === 1'b0
                && pins_i.write_strobe_n === 1'b1;

    // Level write: the last bus value before a strobe rises is kept
    always @*
    begin
        if (wr && pins_i.low_byte_lane_n === 1'b0)
            mem[pins_i.addr][7:0] = dq_i[7:0];
        if (wr && pins_i.high_byte_lane_n === 1'b0)
            mem[pins_i.addr][15:8] = dq_i[15:8];
    end

    // Slowest access path; inertial delay hides glitches as the part does
    assign #(ACC_NS) lane_oe_o = {rd && pins_i.high_byte_lane_n === 1'b0,
        rd && pins_i.low_byte_lane_n === 1'b0};
    assign #(ACC_NS) dq_o = mem[pins_i.addr];

    // Sticky, so one process owns the flag from time zero on
    initial
    begin
        clash_o = 1'b0;
        forever
        begin
            @(host_oe_i or lane_oe_o);
            if (host_oe_i === 1'b1 && lane_oe_o !== 2'h0)
                clash_o = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- hw/asp_host.sv ----
// Host controller for a 256K x 16 asynchronous static RAM.
// Assumes the RAM's data pins are joined to dq_o/dq_oe_o/dq_i outside and
// that supply is stable by the time reset_i is released.
`timescale 1ns/100ps
`default_nettype none

module asp_host
    import asp_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC,
    parameter int SYNC_STAGES    = 2
)(
    input  wire logic              clock_i,
    input  wire logic              reset_i,
    input  wire logic              req_valid_i,
    input  wire asp_req_t          req_i,
    output logic                   req_ready_o,
    output asp_rsp_t               rsp_o,
    output logic                   rsp_valid_o,
    output asp_pins_t              pins_o,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o,
    output logic                   dq_oe_o
);

    // Data must pass the synchroniser while the RAM still drives it
    localparam int READ_HOLD = READ_ACCESS_CYC + SYNC_STAGES - 1;
    localparam int CNT_W = $clog2(POWERUP_CYCLES + READ_HOLD + 1);

    if (POWERUP_CYCLES < 1 || SYNC_STAGES < 2)
    begin : g_bad
        $error("asp_host: powerup count or sync depth out of range");
    end

    typedef struct packed {
        asp_state_t           st;
        logic [CNT_W-1:0]     cnt;
        asp_pins_t            pins;
        logic [NUM_LANES-1:0] lanes;
        logic [DATA_W-1:0]    wdata;
        logic                 dq_oe;
        logic [DATA_W-1:0]    rdata;
        logic                 rvalid;
    } asp_ctl_t;

    localparam asp_ctl_t CTL_RESET = '{
        st:     ST_POWERUP,
        cnt:    CNT_W'(POWERUP_CYCLES - 1),
        pins:   PINS_IDLE,
        lanes:  2'h0,
        wdata:  16'h0000,
        dq_oe:  1'b0,
        rdata:  16'h0000,
        rvalid: 1'b0
    };

    asp_ctl_t             s_r;
    asp_ctl_t             s_nxt;
    logic [DATA_W-1:0]    rd_sync;

    asp_sync #(
        .WIDTH  (DATA_W),
        .STAGES (SYNC_STAGES)
    ) u_rd_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .async_i (dq_i),
        .sync_o  (rd_sync)
    );

    always_comb
    begin
        logic [NUM_LANES-1:0] use_lanes;
        use_lanes = (req_i.lanes == 2'h0) ? 2'h3 : req_i.lanes;
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        unique case (s_r.st)
            ST_POWERUP:
            begin
                // Strobes stay idle for the whole wait
                if (s_r.cnt == '0)
                begin
                    s_nxt.st = ST_IDLE;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            ST_IDLE:
            begin
                if (req_valid_i)
                begin
                    s_nxt.lanes = use_lanes;
                    s_nxt.pins.addr = req_i.addr;
                    s_nxt.pins.chip_select_n = 1'b0;
                    s_nxt.pins.low_byte_lane_n = ~use_lanes[0];
                    s_nxt.pins.high_byte_lane_n = ~use_lanes[1];
                    if (req_i.write)
                    begin
                        s_nxt.pins.write_strobe_n = 1'b0;
                        s_nxt.pins.output_drive_n = 1'b1;
                        s_nxt.wdata = req_i.wdata;
                        s_nxt.dq_oe = 1'b1;
                        s_nxt.cnt = CNT_W'(WRITE_PULSE_CYC - 1);
                        s_nxt.st = ST_WRITE;
                    end
                    else
                    begin
                        s_nxt.pins.write_strobe_n = 1'b1;
                        s_nxt.pins.output_drive_n = 1'b0;
                        s_nxt.dq_oe = 1'b0;
                        s_nxt.cnt = CNT_W'(READ_HOLD - 1);
                        s_nxt.st = ST_READ;
                    end
                end
            end
            ST_READ:
            begin
                if (s_r.cnt == '0)
                begin
                    // Address held one more cycle, well past the data hold
                    s_nxt.pins = PINS_IDLE;
                    s_nxt.pins.addr = s_r.pins.addr;
                    s_nxt.st = ST_RCAP;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            ST_RCAP:
            begin
                // A lane not read is returned as zero
                s_nxt.rdata[LANE_W-1:0] = s_r.lanes[0] ?
                    rd_sync[LANE_W-1:0] : 8'h00;
                s_nxt.rdata[DATA_W-1:LANE_W] = s_r.lanes[1] ?
                    rd_sync[DATA_W-1:LANE_W] : 8'h00;
                s_nxt.rvalid = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            ST_WRITE:
            begin
                if (s_r.cnt == '0)
                begin
                    // Strobes rise together; address and data held a cycle
                    s_nxt.pins = PINS_IDLE;
                    s_nxt.pins.addr = s_r.pins.addr;
                    s_nxt.st = ST_WEND;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            ST_WEND:
            begin
                s_nxt.dq_oe = 1'b0;
                s_nxt.st = ST_IDLE;
            end
            default:
            begin
                s_nxt = CTL_RESET;
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            s_r <= CTL_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign req_ready_o = (s_r.st == ST_IDLE);
    assign rsp_o.data  = s_r.rdata;
    assign rsp_valid_o = s_r.rvalid;
    assign pins_o      = s_r.pins;
    assign dq_o        = s_r.wdata;
    assign dq_oe_o     = s_r.dq_oe;

    // Helper: cycles since reset release, for the power-up check
    logic [CNT_W-1:0] rel_cnt_r;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            rel_cnt_r <= '0;
        end
        else if (rel_cnt_r != '1)
        begin
            rel_cnt_r <= rel_cnt_r + 1'b1;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    sequence wr_start;
        $fell(pins_o.write_strobe_n);
    endsequence

    sequence wr_close;
        pins_o.write_strobe_n && pins_o.chip_select_n && dq_oe_o
            && $stable(pins_o.addr) && $stable(dq_o);
    endsequence

    sequence rd_start;
        $fell(pins_o.output_drive_n);
    endsequence

    sequence rd_finish;
        (!pins_o.output_drive_n && !dq_oe_o)[*2]
            ##1 (pins_o.output_drive_n && !rsp_valid_o)
            ##1 rsp_valid_o;
    endsequence

    reset_idle_a: assert property (
        $fell(reset_i) |-> pins_o.chip_select_n && pins_o.write_strobe_n
            && pins_o.output_drive_n && !dq_oe_o)
        else $error("strobes not idle at reset release");

    powerup_wait_a: assert property (
        !pins_o.chip_select_n |-> rel_cnt_r > CNT_W'(POWERUP_CYCLES))
        else $error("access before power-up wait ended");

    write_select_a: assert property (
        !pins_o.write_strobe_n |-> !pins_o.chip_select_n
            && pins_o.output_drive_n)
        else $error("write strobe without chip select");

    write_lanes_a: assert property (
        !pins_o.write_strobe_n |->
            !(pins_o.low_byte_lane_n && pins_o.high_byte_lane_n))
        else $error("write with no lane enabled");

    write_data_a: assert property (
        !pins_o.write_strobe_n |-> dq_oe_o)
        else $error("write data not driven during write");

    write_hold_a: assert property (
        wr_start |-> !pins_o.chip_select_n ##1 wr_close)
        else $error("write address or data moved before write end");

    read_cond_a: assert property (
        !pins_o.output_drive_n |-> !pins_o.chip_select_n
            && pins_o.write_strobe_n)
        else $error("read without select or with write strobe");

    bus_release_a: assert property (
        !pins_o.output_drive_n |-> !dq_oe_o)
        else $error("host drives data during read");

    read_flow_a: assert property (
        rd_start |-> rd_finish)
        else $error("read cycle length or answer timing wrong");

endmodule

`default_nettype wire

// ---- hw/asp_sync.sv ----
// Multi-stage synchroniser for the data pins coming back from the RAM.
// Assumes its input is asynchronous to clock_i; output is the last stage.
`timescale 1ns/100ps
`default_nettype none

module asp_sync #(
    parameter int WIDTH  = 16,
    parameter int STAGES = 2
)(
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] stage;
    } asp_sync_state_t;

    asp_sync_state_t s_r;
    asp_sync_state_t s_nxt;

    if (STAGES < 2)
    begin : g_bad
        $error("asp_sync needs at least two stages");
    end

    // Stage 0 feeds only stage 1; nothing else may look at it
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.stage[0] = async_i;
        for (int i = 1; i < STAGES; i++)
        begin
            s_nxt.stage[i] = s_r.stage[i-1];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign sync_o = s_r.stage[STAGES-1];

endmodule

`default_nettype wire

// ---- inc/asp_pkg.sv ----
// Constants and types for the asynchronous static RAM host port.
// Assumes a 25 MHz host clock; the access, write setup, deselect and power-up delays are turned into cycles here.
`default_nettype none

package asp_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int NUM_LANES = 2;

    localparam int CLK_PERIOD_NS = 40;

    // Memory timing in ns unless named otherwise
    localparam int ADDRESS_ACCESS_DELAY_NS = 10;
    localparam int OUTPUT_ENABLE_ACCESS_DELAY_NS = 5;
    localparam int SELECT_ACCESS_DELAY_NS = 10;
    localparam int LANE_ACCESS_DELAY_NS = 5;
    localparam int READ_DATA_HOLD_NS = 3;
    localparam int WRITE_ADDR_SETUP_NS = 7;
    localparam int WRITE_SELECT_SETUP_NS = 7;
    localparam int WRITE_DATA_SETUP_NS = 5;
    localparam int WRITE_LANE_SETUP_NS = 7;
    localparam int WRITE_ADDR_HOLD_NS = 0;
    localparam int DESELECT_SLEEP_DELAY_NS = 10;
    localparam int POWERUP_WAIT_US = 100;

    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // Host waits out the slowest of the four read paths
    localparam int READ_ACCESS_CYC = cyc_up(max2(
        max2(ADDRESS_ACCESS_DELAY_NS, OUTPUT_ENABLE_ACCESS_DELAY_NS),
        max2(SELECT_ACCESS_DELAY_NS, LANE_ACCESS_DELAY_NS)));
    localparam int WRITE_PULSE_CYC = cyc_up(max2(
        max2(WRITE_ADDR_SETUP_NS, WRITE_SELECT_SETUP_NS),
        max2(WRITE_DATA_SETUP_NS, WRITE_LANE_SETUP_NS)));
    localparam int DESELECT_CYC = cyc_up(DESELECT_SLEEP_DELAY_NS);
    localparam int POWERUP_CYC = cyc_up(POWERUP_WAIT_US * 1000);

    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_READ,
        ST_RCAP,
        ST_WRITE,
        ST_WEND
    } asp_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              chip_select_n;
        logic              write_strobe_n;
        logic              output_drive_n;
        logic              high_byte_lane_n;
        logic              low_byte_lane_n;
    } asp_pins_t;

    typedef struct packed {
        logic                 write;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    wdata;
        logic [NUM_LANES-1:0] lanes;
    } asp_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
    } asp_rsp_t;

    localparam asp_pins_t PINS_IDLE = '{
        addr:             18'h00000,
        chip_select_n:    1'b1,
        write_strobe_n:   1'b1,
        output_drive_n:   1'b1,
        high_byte_lane_n: 1'b1,
        low_byte_lane_n:  1'b1
    };

endpackage

`default_nettype wire
